/* inc/gpx_consts.svh */
// Purpose: register offsets, reset values and field positions of the gpio expander
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only
`ifndef GPX_CONSTS_SVH
`define GPX_CONSTS_SVH

// ======================================================================
// register offsets
`define GPX_ADDR_PIN_LEVEL   8'h00
`define GPX_ADDR_DIRECTION   8'h01
`define GPX_ADDR_PULLUP      8'h02
`define GPX_ADDR_PULLDOWN    8'h03
`define GPX_ADDR_UNUSED      8'h04
`define GPX_ADDR_EVENT_MASK  8'h05
`define GPX_ADDR_EDGE_UPPER  8'h06
`define GPX_ADDR_EDGE_LOWER  8'h07
`define GPX_ADDR_IRQ_ORIGIN  8'h08
`define GPX_ADDR_EDGE_SEEN   8'h09
`define GPX_ADDR_FN_SELECT   8'h10
`define GPX_ADDR_TABLE_0     8'h11
`define GPX_ADDR_TABLE_1     8'h12
`define GPX_ADDR_TABLE_2     8'h13
`define GPX_ADDR_TABLE_3     8'h14
`define GPX_ADDR_TABLE_4     8'h15

// ======================================================================
// reset values
`define GPX_RST_PIN_LEVEL    8'hFF
`define GPX_RST_DIRECTION    8'hFF
`define GPX_RST_PULLUP       8'h00
`define GPX_RST_PULLDOWN     8'h00
`define GPX_RST_EVENT_MASK   8'hFF
`define GPX_RST_EDGE_SEL     8'h00
`define GPX_RST_FLAGS        8'h00
`define GPX_RST_FN_SELECT    8'h00
`define GPX_RST_TABLE        8'h00
`define GPX_READ_UNMAPPED    8'h00

// ======================================================================
// field positions inside logic_fn_select, and pins per edge-select register
`define GPX_FN_LOWER_LSB     0
`define GPX_FN_UPPER_LSB     4
`define GPX_FN_SELECT_MASK   8'h33
`define GPX_EDGE_PINS_PER_REG 4

`endif

/* inc/gpx_pkg.sv */
// Purpose: shared types of the gpio expander
// Assumes: nothing beyond the constants header
// Notes:   codes follow declaration order 0..3
package gpx_pkg;

   // ======================================================================
   // edge-select code of one pin
   typedef enum logic [1:0] {
      GPX_EDGE_NONE,
      GPX_EDGE_RISE,
      GPX_EDGE_FALL,
      GPX_EDGE_BOTH
   } gpx_edge_e;

   // ======================================================================
   // lookup-logic mode of one nibble
   typedef enum logic [1:0] {
      GPX_FN_OFF,
      GPX_FN_TWO_IN,
      GPX_FN_THREE_IN,
      GPX_FN_THREE_TWO
   } gpx_fnmode_e;

   typedef logic [7:0] gpx_byte_t;

endpackage

/* design/gpx_pin_sync.sv */
// Purpose: three-stage synchroniser and edge finder for one pin
// Assumes: pin level is asynchronous to clk
// Notes:   a change counts once the second and third stages agree
`timescale 1ns/100ps
module gpx_pin_sync (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // pin side
   input wire logic pinRaw,
   // core side
   output logic pinLevel,
   output logic rise,
   output logic fall
);
   logic meta_q;
   logic stage2_q;
   logic stage3_q;
   logic level_q;
   logic levelPrev_q;

   // ======================================================================
   // capture chain; first stage feeds only the second
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= 1'b0;
         stage2_q <= 1'b0;
         stage3_q <= 1'b0;
      end else if (clkEn) begin
         meta_q <= pinRaw;
         stage2_q <= meta_q;
         stage3_q <= stage2_q;
      end
   end

   // accepted level, compared with last clock's to find edges
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         level_q <= 1'b0;
         levelPrev_q <= 1'b0;
      end else if (clkEn) begin
         if (stage2_q == stage3_q) begin
            level_q <= stage3_q;
         end
         levelPrev_q <= level_q;
      end
   end

   // one-cycle pulses; gated by clkEn so a frozen core sees none twice
   assign pinLevel = level_q;
   assign rise = clkEn & level_q & ~levelPrev_q;
   assign fall = clkEn & ~level_q & levelPrev_q;
endmodule

/* design/gpx_lookup_logic.sv */
// Purpose: truth-table logic functions mapped onto pin groups
// Assumes: pin inputs are synchronised levels
// Notes:   purely combinational; the caller registers the pin drive
`timescale 1ns/100ps
module gpx_lookup_logic (
   // mode fields
   input wire gpx_pkg::gpx_fnmode_e lowerMode,
   input wire gpx_pkg::gpx_fnmode_e upperMode,
   // pin levels
   input wire logic [7:0] pinLevel,
   // truth tables
   input wire logic [7:0] table0,
   input wire logic [7:0] table1,
   input wire logic [7:0] table2,
   input wire logic [7:0] table3,
   input wire logic [7:0] table4,
   // results
   output logic [7:0] fnValue,
   output logic [7:0] fnDrive,
   output logic [7:0] fnInput
);
   import gpx_pkg::*;

   logic [1:0] lowIdx2;
   logic [2:0] lowIdx3;
   logic [1:0] upIdx2;
   logic [2:0] upIdx3;

   assign lowIdx2 = pinLevel[1:0];
   assign lowIdx3 = pinLevel[2:0];
   assign upIdx2 = pinLevel[5:4];
   assign upIdx3 = pinLevel[6:4];

   // ======================================================================
   // lower nibble decode, then upper; lower 3-to-2 takes pin 4 and
   // leaves pins 7:5 plain, so it overrides the upper field
   always_comb begin
      fnValue = 8'h00;
      fnDrive = 8'h00;
      fnInput = 8'h00;
      case (lowerMode)
         GPX_FN_TWO_IN: begin
            fnValue[2] = table0[lowIdx2];
            fnDrive[2] = 1'b1;
            fnInput[1:0] = 2'b11;
         end
         GPX_FN_THREE_IN: begin
            fnValue[3] = table2[lowIdx3];
            fnDrive[3] = 1'b1;
            fnInput[2:0] = 3'b111;
         end
         GPX_FN_THREE_TWO: begin
            fnValue[3] = table4[lowIdx3];
            fnValue[4] = table3[lowIdx3];
            fnDrive[4:3] = 2'b11;
            fnInput[2:0] = 3'b111;
         end
         default: begin
            fnValue[0] = 1'b0; // plain gpio on pins 3:0
         end
      endcase
      if (lowerMode != GPX_FN_THREE_TWO) begin
         case (upperMode)
            GPX_FN_TWO_IN: begin
               fnValue[6] = table0[{1'b1, upIdx2}];
               fnDrive[6] = 1'b1;
               fnInput[5:4] = 2'b11;
            end
            GPX_FN_THREE_IN: begin
               fnValue[7] = table1[upIdx3];
               fnDrive[7] = 1'b1;
               fnInput[6:4] = 3'b111;
            end
            default: begin
               fnInput[7:4] = 4'h0; // off or reserved: plain gpio
            end
         endcase
      end
   end
endmodule

/* design/gpx_regbank.sv */
// Purpose: register bank and pin logic of an eight-channel gpio expander
// Assumes: a serial-bus front end outside drives the register port
// Notes:   read data appears one clock after the read strobe
`timescale 1ns/100ps
`include "gpx_consts.svh"

module gpx_regbank #(
   parameter int PIN_COUNT = 8
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // register port
   input wire gpx_pkg::gpx_byte_t regAddr,
   input wire gpx_pkg::gpx_byte_t regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output gpx_pkg::gpx_byte_t regRdData,
   // gpio pins
   input wire logic [PIN_COUNT-1:0] pinIn,
   output logic [PIN_COUNT-1:0] pinOut,
   output logic [PIN_COUNT-1:0] pinOe,
   output logic [PIN_COUNT-1:0] pullUpOn,
   output logic [PIN_COUNT-1:0] pullDownOn,
   // open-drain interrupt pin
   input wire logic irqOutNIn,
   output logic irqOutNOut,
   output logic irqOutNOe
);
   import gpx_pkg::*;

   // ======================================================================
   // register state
   gpx_byte_t pinValue_q;
   gpx_byte_t directionCtl_q;
   gpx_byte_t pullupEnable_q;
   gpx_byte_t pulldownEnable_q;
   gpx_byte_t eventIrqMask_q;
   gpx_byte_t edgeSelectUpper_q;
   gpx_byte_t edgeSelectLower_q;
   gpx_byte_t irqOriginFlags_q;
   gpx_byte_t irqOriginFlags_d;
   gpx_byte_t edgeSeenFlags_q;
   gpx_byte_t edgeSeenFlags_d;
   gpx_byte_t logicFnSelect_q;
   gpx_byte_t truthTable0_q;
   gpx_byte_t truthTable1_q;
   gpx_byte_t truthTable2_q;
   gpx_byte_t truthTable3_q;
   gpx_byte_t truthTable4_q;
   gpx_byte_t regRdData_q;
   logic [PIN_COUNT-1:0] pinOut_q;
   logic [PIN_COUNT-1:0] pinOe_q;
   logic irqOutNOe_q;
   logic irqPinSeenLow_q;

   // ======================================================================
   // decoded strobes and per-pin event wires
   logic wrPinValue;
   logic wrDirection;
   logic wrPullup;
   logic wrPulldown;
   logic wrMask;
   logic wrEdgeUpper;
   logic wrEdgeLower;
   logic wrOrigin;
   logic wrSeen;
   logic wrFnSelect;
   logic wrTable0;
   logic wrTable1;
   logic wrTable2;
   logic wrTable3;
   logic wrTable4;
   logic [PIN_COUNT-1:0] pinLevel;
   logic [PIN_COUNT-1:0] pinRise;
   logic [PIN_COUNT-1:0] pinFall;
   logic [PIN_COUNT-1:0] edgeHit;
   logic [PIN_COUNT-1:0] edgeSelChanged;
   logic [PIN_COUNT-1:0] flagClear;
   logic [PIN_COUNT-1:0] fnValue;
   logic [PIN_COUNT-1:0] fnDrive;
   logic [PIN_COUNT-1:0] fnInput;
   gpx_fnmode_e lowerMode;
   gpx_fnmode_e upperMode;

   // ======================================================================
   // write address decode
   always_comb begin
      wrPinValue = 1'b0;
      wrDirection = 1'b0;
      wrPullup = 1'b0;
      wrPulldown = 1'b0;
      wrMask = 1'b0;
      wrEdgeUpper = 1'b0;
      wrEdgeLower = 1'b0;
      wrOrigin = 1'b0;
      wrSeen = 1'b0;
      wrFnSelect = 1'b0;
      wrTable0 = 1'b0;
      wrTable1 = 1'b0;
      wrTable2 = 1'b0;
      wrTable3 = 1'b0;
      wrTable4 = 1'b0;
      if (!regWrEn) begin
         wrPinValue = 1'b0;
      end else if (regAddr == `GPX_ADDR_PIN_LEVEL) begin
         wrPinValue = 1'b1;
      end else if (regAddr == `GPX_ADDR_DIRECTION) begin
         wrDirection = 1'b1;
      end else if (regAddr == `GPX_ADDR_PULLUP) begin
         wrPullup = 1'b1;
      end else if (regAddr == `GPX_ADDR_PULLDOWN) begin
         wrPulldown = 1'b1;
      end else if (regAddr == `GPX_ADDR_EVENT_MASK) begin
         wrMask = 1'b1;
      end else if (regAddr == `GPX_ADDR_EDGE_UPPER) begin
         wrEdgeUpper = 1'b1;
      end else if (regAddr == `GPX_ADDR_EDGE_LOWER) begin
         wrEdgeLower = 1'b1;
      end else if (regAddr == `GPX_ADDR_IRQ_ORIGIN) begin
         wrOrigin = 1'b1;
      end else if (regAddr == `GPX_ADDR_EDGE_SEEN) begin
         wrSeen = 1'b1;
      end else if (regAddr == `GPX_ADDR_FN_SELECT) begin
         wrFnSelect = 1'b1;
      end else if (regAddr == `GPX_ADDR_TABLE_0) begin
         wrTable0 = 1'b1;
      end else if (regAddr == `GPX_ADDR_TABLE_1) begin
         wrTable1 = 1'b1;
      end else if (regAddr == `GPX_ADDR_TABLE_2) begin
         wrTable2 = 1'b1;
      end else if (regAddr == `GPX_ADDR_TABLE_3) begin
         wrTable3 = 1'b1;
      end else if (regAddr == `GPX_ADDR_TABLE_4) begin
         wrTable4 = 1'b1;
      end
   end

   // ======================================================================
   // plain configuration registers, read/write except pin value, whose offset reads back the pin levels
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pinValue_q <= `GPX_RST_PIN_LEVEL;
         directionCtl_q <= `GPX_RST_DIRECTION;
         pullupEnable_q <= `GPX_RST_PULLUP;
         pulldownEnable_q <= `GPX_RST_PULLDOWN;
         eventIrqMask_q <= `GPX_RST_EVENT_MASK;
      end else if (clkEn) begin
         if (wrPinValue) begin
            pinValue_q <= regWrData;
         end
         if (wrDirection) begin
            directionCtl_q <= regWrData;
         end
         if (wrPullup) begin
            pullupEnable_q <= regWrData;
         end
         if (wrPulldown) begin
            pulldownEnable_q <= regWrData;
         end
         if (wrMask) begin
            eventIrqMask_q <= regWrData;
         end
      end
   end

   // edge-select registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         edgeSelectUpper_q <= `GPX_RST_EDGE_SEL;
         edgeSelectLower_q <= `GPX_RST_EDGE_SEL;
      end else if (clkEn) begin
         if (wrEdgeUpper) begin
            edgeSelectUpper_q <= regWrData;
         end
         if (wrEdgeLower) begin
            edgeSelectLower_q <= regWrData;
         end
      end
   end

   // lookup-logic mode and truth tables
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         logicFnSelect_q <= `GPX_RST_FN_SELECT;
         truthTable0_q <= `GPX_RST_TABLE;
         truthTable1_q <= `GPX_RST_TABLE;
         truthTable2_q <= `GPX_RST_TABLE;
         truthTable3_q <= `GPX_RST_TABLE;
         truthTable4_q <= `GPX_RST_TABLE;
      end else if (clkEn) begin
         if (wrFnSelect) begin
            logicFnSelect_q <= regWrData & `GPX_FN_SELECT_MASK; // reserved bits held 0
         end
         if (wrTable0) begin
            truthTable0_q <= regWrData;
         end
         if (wrTable1) begin
            truthTable1_q <= regWrData;
         end
         if (wrTable2) begin
            truthTable2_q <= regWrData;
         end
         if (wrTable3) begin
            truthTable3_q <= regWrData;
         end
         if (wrTable4) begin
            truthTable4_q <= regWrData;
         end
      end
   end

   // ======================================================================
   // per-pin synchroniser, edge match and edge-code change detect
   for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
      localparam int FLD = 2 * (n % `GPX_EDGE_PINS_PER_REG);
      logic [1:0] selCur;
      logic [1:0] selNew;
      logic selWr;
      gpx_edge_e sel;

      gpx_pin_sync u_sync (
         .clk(clk),
         .sys_rst(sys_rst),
         .clkEn(clkEn),
         .pinRaw(pinIn[n]),
         .pinLevel(pinLevel[n]),
         .rise(pinRise[n]),
         .fall(pinFall[n])
      );

      // pins below four live in the lower register
      assign selCur = (n < `GPX_EDGE_PINS_PER_REG) ? edgeSelectLower_q[FLD+1:FLD]
                                                   : edgeSelectUpper_q[FLD+1:FLD];
      assign selWr = (n < `GPX_EDGE_PINS_PER_REG) ? wrEdgeLower : wrEdgeUpper;
      assign selNew = regWrData[FLD+1:FLD];
      assign sel = gpx_edge_e'(selCur);
      assign edgeSelChanged[n] = selWr & (selNew != selCur);

      // code decode onto the rise and fall pulses
      always_comb begin
         case (sel)
            GPX_EDGE_RISE: edgeHit[n] = pinRise[n];
            GPX_EDGE_FALL: edgeHit[n] = pinFall[n];
            GPX_EDGE_BOTH: edgeHit[n] = pinRise[n] | pinFall[n];
            default: edgeHit[n] = 1'b0;
         endcase
      end
   end

   // ======================================================================
   // sticky event flags; a new edge wins over a clear in the same cycle
   assign flagClear = (wrOrigin | wrSeen) ? regWrData : 8'h00;

   always_comb begin
      irqOriginFlags_d = (irqOriginFlags_q & ~flagClear) | (edgeHit & ~eventIrqMask_q);
      edgeSeenFlags_d = (edgeSeenFlags_q & ~(flagClear | edgeSelChanged)) | edgeHit;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irqOriginFlags_q <= `GPX_RST_FLAGS;
         edgeSeenFlags_q <= `GPX_RST_FLAGS;
      end else if (clkEn) begin
         irqOriginFlags_q <= irqOriginFlags_d;
         edgeSeenFlags_q <= edgeSeenFlags_d;
      end
   end

   // ======================================================================
   // interrupt pin: open drain, only ever pulls low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irqOutNOe_q <= 1'b0;
      end else if (clkEn) begin
         irqOutNOe_q <= |irqOriginFlags_d;
      end
   end

   // wire level sampled into a flag that no register reads back; pin is shared open drain
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irqPinSeenLow_q <= 1'b0;
      end else if (clkEn) begin
         irqPinSeenLow_q <= ~irqOutNIn & irqOutNOe_q;
      end
   end

   assign irqOutNOut = 1'b0;
   assign irqOutNOe = irqOutNOe_q;

   // ======================================================================
   // lookup logic and pin drive
   assign lowerMode = gpx_fnmode_e'(logicFnSelect_q[`GPX_FN_LOWER_LSB +: 2]);
   assign upperMode = gpx_fnmode_e'(logicFnSelect_q[`GPX_FN_UPPER_LSB +: 2]);

   gpx_lookup_logic u_lookup (
      .lowerMode(lowerMode),
      .upperMode(upperMode),
      .pinLevel(pinLevel),
      .table0(truthTable0_q),
      .table1(truthTable1_q),
      .table2(truthTable2_q),
      .table3(truthTable3_q),
      .table4(truthTable4_q),
      .fnValue(fnValue),
      .fnDrive(fnDrive),
      .fnInput(fnInput)
   );

   // registered drive; function pins override direction_ctl both ways
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pinOut_q <= `GPX_RST_PIN_LEVEL;
         pinOe_q <= '0; // every pin an input out of reset
      end else if (clkEn) begin
         pinOut_q <= (fnDrive & fnValue) | (~fnDrive & pinValue_q);
         pinOe_q <= fnDrive | (~directionCtl_q & ~fnInput);
      end
   end

   assign pinOut = pinOut_q;
   assign pinOe = pinOe_q;
   assign pullUpOn = pullupEnable_q;
   assign pullDownOn = pulldownEnable_q;

   // ======================================================================
   // read path; reserved slot and unmapped addresses read as zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         regRdData_q <= `GPX_READ_UNMAPPED;
      end else if (clkEn && regRdEn) begin
         if (regAddr == `GPX_ADDR_PIN_LEVEL) begin
            regRdData_q <= pinLevel; // sampled pins, any direction
         end else if (regAddr == `GPX_ADDR_DIRECTION) begin
            regRdData_q <= directionCtl_q;
         end else if (regAddr == `GPX_ADDR_PULLUP) begin
            regRdData_q <= pullupEnable_q;
         end else if (regAddr == `GPX_ADDR_PULLDOWN) begin
            regRdData_q <= pulldownEnable_q;
         end else if (regAddr == `GPX_ADDR_EVENT_MASK) begin
            regRdData_q <= eventIrqMask_q;
         end else if (regAddr == `GPX_ADDR_EDGE_UPPER) begin
            regRdData_q <= edgeSelectUpper_q;
         end else if (regAddr == `GPX_ADDR_EDGE_LOWER) begin
            regRdData_q <= edgeSelectLower_q;
         end else if (regAddr == `GPX_ADDR_IRQ_ORIGIN) begin
            regRdData_q <= irqOriginFlags_q;
         end else if (regAddr == `GPX_ADDR_EDGE_SEEN) begin
            regRdData_q <= edgeSeenFlags_q;
         end else if (regAddr == `GPX_ADDR_FN_SELECT) begin
            regRdData_q <= logicFnSelect_q;
         end else if (regAddr == `GPX_ADDR_TABLE_0) begin
            regRdData_q <= truthTable0_q;
         end else if (regAddr == `GPX_ADDR_TABLE_1) begin
            regRdData_q <= truthTable1_q;
         end else if (regAddr == `GPX_ADDR_TABLE_2) begin
            regRdData_q <= truthTable2_q;
         end else if (regAddr == `GPX_ADDR_TABLE_3) begin
            regRdData_q <= truthTable3_q;
         end else if (regAddr == `GPX_ADDR_TABLE_4) begin
            regRdData_q <= truthTable4_q;
         end else begin
            regRdData_q <= `GPX_READ_UNMAPPED;
         end
      end
   end

   assign regRdData = regRdData_q;
endmodule

/* testbench/gpx_regbank_assertions.sv */
// Purpose: port checks of the gpio expander register bank
// Assumes: lookup modes are off whenever direction is written
// Notes:   bound onto every register bank instance
`timescale 1ns/100ps
module gpx_regbank_assertions #(
   parameter int PIN_COUNT = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // register port
   input wire gpx_pkg::gpx_byte_t regAddr,
   input wire gpx_pkg::gpx_byte_t regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire gpx_pkg::gpx_byte_t regRdData,
   // pins
   input wire logic [PIN_COUNT-1:0] pinOut,
   input wire logic [PIN_COUNT-1:0] pinOe,
   input wire logic [PIN_COUNT-1:0] pullUpOn,
   input wire logic [PIN_COUNT-1:0] pullDownOn,
   input wire logic irqOutNOut,
   input wire logic irqOutNOe
);
   import gpx_pkg::*;
   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // one accepted write to offset a
   sequence wr_s(logic [7:0] a);
      clkEn && regWrEn && regAddr == a;
   endsequence
   chk_pullup_write: assert property (wr_s(8'h02) |=> pullUpOn == $past(regWrData))
      else $error("pull-up enables wrong");
   chk_pulldn_write: assert property (wr_s(8'h03) |=> pullDownOn == $past(regWrData))
      else $error("pull-down enables wrong");
   chk_oe_follow: assert property (wr_s(8'h01) |-> ##2 pinOe == ~$past(regWrData, 2))
      else $error("output enables wrong");
   chk_rd_unmapped: assert property (clkEn && regRdEn && regAddr == 8'h04 |=> regRdData == 0)
      else $error("reserved slot not zero");
   chk_rd_hold: assert property (!(clkEn && regRdEn) |=> $stable(regRdData))
      else $error("read data moved");
   chk_irq_drain: assert property (irqOutNOut == 1'b0)
      else $error("interrupt drive high");
   // pins held still by the bench around this clear
   chk_irq_release: assert property (wr_s(8'h08) and regWrData == 8'hFF |=> ##1 !irqOutNOe)
      else $error("interrupt not released");
   chk_reset_vals: assert property ($fell(sys_rst) |-> pinOe == 0 && pullUpOn == 0
      && pullDownOn == 0 && !irqOutNOe && pinOut == '1) else $error("reset state wrong");
endmodule
bind gpx_regbank gpx_regbank_assertions #(.PIN_COUNT(PIN_COUNT)) u_chk (.*);

/* testbench/gpx_pin_driver.sv */
// Purpose: board model of the expander pins
// Assumes: device drive beats board drive
// Notes:   pin 0 carries the link clock while a frame runs
`timescale 1ns/100ps
module gpx_pin_driver (
   // clock
   input wire logic clk,
   // device side
   input wire logic [7:0] pinOut,
   input wire logic [7:0] pinOe,
   input wire logic [7:0] pullUpOn,
   input wire logic [7:0] pullDownOn,
   // board side
   input wire logic [7:0] extLevel,
   input wire logic [7:0] extEn,
   input wire logic linkRun,
   output logic [7:0] pinIn
);
   logic linkClk = 1'b0;
   logic [7:0] floatQ = 8'h00;
   // ==========================================
   // link clock idles low between frames
   always #200 linkClk = linkRun ? ~linkClk : 1'b0;
   // undriven wires wander so no stale level reads as valid
   always @(posedge clk) floatQ <= ~floatQ;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pinOe[i]) pinIn[i] = pinOut[i];
         else if (i == 0 && linkRun) pinIn[i] = linkClk;
         else if (extEn[i]) pinIn[i] = extLevel[i];
         else if (pullUpOn[i] || pullDownOn[i]) pinIn[i] = pullUpOn[i];
         else pinIn[i] = floatQ[i];
      end
   end
endmodule

/* testbench/tb_top.sv */
// Purpose: self-checking bench of the gpio expander register bank
// Assumes: clkEn high except in the hold scenario; pins resolved by the board model
// Notes:   inputs move 2 ns after the rising edge
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin nFail++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
   import gpx_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic regWrEn = 1'b0, regRdEn = 1'b0, linkRun = 1'b0, clkEn = 1'b1, irqOutNOe;
   gpx_byte_t regAddr = 8'h00, regWrData = 8'h00, regRdData, extLevel = 8'h00, extEn = 8'h00;
   logic [7:0] pinIn, pinOut, pinOe, pullUpOn, pullDownOn, tb0, tb1, tb2, tb3, tb4, e;
   int nFail = 0, checked = 0;
   // ==========================================
   // clock, device, board
   always #25 clk = ~clk;
   gpx_regbank DUT (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullUpOn(pullUpOn),
      .pullDownOn(pullDownOn), .irqOutNIn(~irqOutNOe), .irqOutNOut(), .irqOutNOe(irqOutNOe));
   gpx_pin_driver u_pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullUpOn(pullUpOn),
      .pullDownOn(pullDownOn), .extLevel(extLevel), .extEn(extEn), .linkRun(linkRun),
      .pinIn(pinIn));
   task automatic testDone();
      if (nFail == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // idle cycle after each access keeps strobes from being set twice at once
   task automatic wr(gpx_byte_t a, gpx_byte_t d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      cyc(1);
      regWrEn = 1'b0;
      cyc(1);
   endtask
   task automatic rd(gpx_byte_t a, gpx_byte_t x);
      regAddr = a;
      regRdEn = 1'b1;
      cyc(1);
      regRdEn = 1'b0;
      `CHK($sformatf("reg %h", a), x, regRdData)
      cyc(1);
   endtask
   // ==========================================
   // scenarios
   task automatic tReset();
      rd(8'h01, 8'hFF);
      rd(8'h05, 8'hFF);
      for (int a = 2; a < 'h22; a++) if (a != 5 && (a < 10 || a > 'hF)) rd(8'(a), 8'h00);
   endtask
   task automatic tPins();
      wr(8'h00, 8'hA5);
      wr(8'h01, 8'h00);
      `CHK("pinOut", 8'hA5, pinOut)
      cyc(4);
      rd(8'h00, 8'hA5);
      wr(8'h01, 8'hFF);
      wr(8'h02, 8'h0F);
      wr(8'h03, 8'hF0);
      cyc(4);
      rd(8'h00, 8'h0F);
      extEn = 8'hFF;
      cyc(8);
   endtask
   // frozen core must ignore a write presented while clkEn is low
   task automatic tHold();
      clkEn = 1'b0;
      wr(8'h02, 8'hAA);
      clkEn = 1'b1;
      rd(8'h02, 8'h0F);
   endtask
   task automatic tEdge();
      wr(8'h05, 8'hFD);
      wr(8'h06, 8'h04);
      for (int c = 0; c < 4; c++) begin
         wr(8'h07, 8'(c << 2));
         extLevel = 8'h22;
         cyc(8);
         rd(8'h08, c[0] ? 8'h02 : 8'h00);
         rd(8'h09, c[0] ? 8'h22 : 8'h20);
         `CHK("irq", c[0], irqOutNOe)
         wr(8'h09, 8'h22);
         rd(8'h08, 8'h00);
         `CHK("irq", 1'b0, irqOutNOe)
         extLevel = 8'h00;
         cyc(8);
         rd(8'h08, c[1] ? 8'h02 : 8'h00);
         wr(8'h08, 8'hFF);
         rd(8'h09, 8'h00);
      end
      extLevel = 8'h02;
      cyc(8);
      wr(8'h07, 8'h04);
      rd(8'h09, 8'h00);
      rd(8'h08, 8'h02);
      wr(8'h08, 8'hFF);
   endtask
   task automatic tFn(gpx_byte_t mode, gpx_byte_t en, gpx_byte_t oe);
      extEn = en;
      wr(8'h10, mode);
      for (int k = 0; k < 8; k++) begin
         extLevel = 8'((k << 4) | k) & en;
         cyc(8);
         case (mode)
            8'h11: e = {1'b0, tb0[4 + k % 4], 3'b0, tb0[k % 4], 2'b0};
            8'h22: e = {tb1[k], 3'b0, tb2[k], 3'b0};
            default: e = {3'b0, tb3[k], tb4[k], 3'b0};
         endcase
         `CHK("lookup out", e, pinOut & oe)
      end
      `CHK("lookup oe", oe, pinOe)
   endtask
   // link clock on pin 0, both edges, unmasked
   task automatic tLink();
      extEn = 8'hFF;
      wr(8'h10, 8'h00);
      wr(8'h07, 8'h03);
      wr(8'h05, 8'hFE);
      wr(8'h08, 8'hFF); // drops pin 1 flags left by the lookup scenarios
      linkRun = 1'b1;
      cyc(40);
      linkRun = 1'b0;
      cyc(8);
      rd(8'h08, 8'h01);
      `CHK("irq", 1'b1, irqOutNOe)
      wr(8'h08, 8'hFF);
      rd(8'h09, 8'h00);
   endtask
   initial begin
      {tb0, tb1, tb2, tb3, tb4} = 40'h6896E85AC3;
      cyc(2);
      sys_rst = 1'b0;
      tReset();
      tPins();
      tHold();
      tEdge();
      wr(8'h11, tb0);
      wr(8'h12, tb1);
      wr(8'h13, tb2);
      wr(8'h14, tb3);
      wr(8'h15, tb4);
      tFn(8'h11, 8'h33, 8'h44);
      tFn(8'h22, 8'h77, 8'h88);
      tFn(8'h33, 8'h07, 8'h18); // upper reserved code, overridden by lower 3-to-2
      tLink();
      testDone();
   end
   // run needs about 25 us; sixteen times that means a hang
   initial begin
      #400000;
      nFail++;
      testDone();
   end
endmodule
